// *** pkg/pfpm_regs.vh ***
/*
 Constants of the pin function and power-down mux: state codes,
 configuration addresses, reset values and pin group widths.
 Assumes it is included by bare name from the design files.
*/
//
// Behaviour
// - Select bit 1 routes multi-function I/O, 0 the standard function.
// - Serial peripheral clock, out, in sit on bits 15..13, reset 0.
// - Card strobes, selects, waits, direction on bits 11..2, reset 1.
// - IR power, carrier detect bits 17,16 reset 1; bus clock 12 is 0.
// - Power-down is the inverse of main-supply-on AND supply present.
// - Per-pin sleep applies when power-down and its enable bit both set; code also needs armed_r, set in running once supply is present.
// - Twelve general I/O: pulled down at reset, inputs running, sleep set.
// - Memory pins follow memory sleep condition; low in all three states; code holds them low only in power-on reset or under memory sleep.
// - Read strobe low at reset and sleep, high when running.
// - System and 6 MHz oscillators run only when running; 32 kHz always.
// - Boot select pulled down at reset and sleep, high running.
// - Codec outputs, fast IR low; codec inputs pulled down off-run.
// - Standby power with system supply off enters power-on reset state.
// - On-button press in power-on reset starts the running state.
// - Sleep keeps this block alive with the system supply removed.
// - Software may change pin states after first power-up.
// - Bus grant tri-states memory data, strobes and memory control pins.
`ifndef PFPM_REGS_VH
`define PFPM_REGS_VH

// ----------------------------------------
// Power states (one-hot)
// ----------------------------------------
`define PFPM_ST_W         3
`define PFPM_ST_POR       3'h1
`define PFPM_ST_RUN       3'h2
`define PFPM_ST_SLEEP     3'h4

// ----------------------------------------
// Configuration write addresses
// ----------------------------------------
`define PFPM_AW           3
`define PFPM_A_MF_SEL     3'h0
`define PFPM_A_MF_SLP_EN  3'h1
`define PFPM_A_MF_SLP_DRV 3'h2
`define PFPM_A_MF_SLP_LVL 3'h3
`define PFPM_A_GIO_SLP_EN 3'h4
`define PFPM_A_GIO_SLP_DRV 3'h5
`define PFPM_A_GIO_SLP_LVL 3'h6

// ----------------------------------------
// Reset values, multi-function bits 17..2 and general I/O sleep enables
// ----------------------------------------
`define PFPM_MF_SEL_RST   16'hC3FF
`define PFPM_MF_SLP_RST   16'h0FFF
`define PFPM_MF_POR_LOW   16'h3000
`define PFPM_GIO_SLP_RST  12'hFFF

// ----------------------------------------
// Pin group widths
// ----------------------------------------
`define PFPM_MEM_DW       32
`define PFPM_MEM_AW       13
`define PFPM_MEM_CW       12
`define PFPM_GIO_W        12

`endif

// *** hdl/pfpm_pin_cell.v ***
/*
 One multiplexed pin: picks standard or multi-function drive, applies
 power-on reset and sleep states, and returns the synchronised input.
 Assumes the pad resolves out, active-low enable and pull-down.
*/
`timescale 1ns/1ps

module pfpm_pin_cell (
    input  wire clock,
    input  wire resetn,
    input  wire sel,
    input  wire por,
    input  wire por_low,
    input  wire sleep,
    input  wire slp_drive,
    input  wire slp_level,
    input  wire std_out,
    input  wire std_oe_n,
    input  wire mio_out,
    input  wire mio_oe_n,
    input  wire pin_in,
    output reg  pin_out,
    output reg  pin_oe_n,
    output reg  pin_pull_dn,
    output reg  std_in,
    output reg  mio_in
);

    reg pin_s1_r;
    reg pin_s2_r;
    reg out_nxt;
    reg oe_n_nxt;
    reg pull_nxt;

    // ----------------------------------------
    // Pad drive selection
    // ----------------------------------------
    always @* begin
        out_nxt  = 1'b0;
        oe_n_nxt = 1'b1;
        pull_nxt = 1'b0;
        if (por) begin
            oe_n_nxt = ~por_low;
            pull_nxt = ~por_low;
        end else if (sleep) begin
            out_nxt  = slp_level;
            oe_n_nxt = ~slp_drive;
            pull_nxt = ~slp_drive;
        end else if (sel) begin
            out_nxt  = mio_out;
            oe_n_nxt = mio_oe_n;
        end else begin
            out_nxt  = std_out;
            oe_n_nxt = std_oe_n;
        end
    end

    // Registered pad, two-flop input, routed input
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_out     <= 1'b0;
            pin_oe_n    <= 1'b1;
            pin_pull_dn <= 1'b1;
            pin_s1_r    <= 1'b0;
            pin_s2_r    <= 1'b0;
            std_in      <= 1'b0;
            mio_in      <= 1'b0;
        end else begin
            pin_out     <= out_nxt;
            pin_oe_n    <= oe_n_nxt;
            pin_pull_dn <= pull_nxt;
            pin_s1_r    <= pin_in;
            pin_s2_r    <= pin_s1_r;
            std_in      <= pin_s2_r & ~sel & ~sleep & ~por;
            mio_in      <= pin_s2_r & sel & ~sleep & ~por;
        end
    end

endmodule

// *** hdl/pfpm_top.v ***
/*
 Pin function and power-down mux: power state sequencer, select and
 sleep configuration, multiplexed and dedicated pin gating.
 Assumes pins resolved by the pad ring from out, enable and pull.
*/
`timescale 1ns/1ps
`include "pfpm_regs.vh"

module pfpm_top (
    input  wire                      clock,
    input  wire                      resetn,
    // Power inputs
    input  wire                      power_on_reset_n,
    input  wire                      on_button,
    input  wire                      system_supply_present,
    input  wire                      main_supply_on,
    input  wire                      memory_sleep_condition,
    input  wire                      bus_grant_n,
    // Configuration write port
    input  wire                      cfg_wr_en,
    input  wire [`PFPM_AW-1:0]       cfg_wr_addr,
    input  wire [15:0]               cfg_wr_data,
    // Configuration and state readback
    output wire [17:2]               multi_function_select,
    output wire [17:2]               multi_function_sleep_enable,
    output wire [`PFPM_GIO_W-1:0]    general_io_sleep_enable,
    output wire [`PFPM_ST_W-1:0]     power_state,
    output wire                      power_down,
    // Power outputs
    output reg                       system_power_switch,
    output reg                       sys_osc_enable,
    output reg                       osc_6mhz_enable,
    output reg                       osc_32khz_enable,
    // Multiplexed pins, bits 17..2
    input  wire [17:2]               mf_std_out,
    input  wire [17:2]               mf_std_oe_n,
    input  wire [17:2]               multi_function_io_out,
    input  wire [17:2]               multi_function_io_oe_n,
    input  wire [17:2]               mf_pin_in,
    output wire [17:2]               mf_pin_out,
    output wire [17:2]               mf_pin_oe_n,
    output wire [17:2]               mf_pin_pull_dn,
    output wire [17:2]               mf_std_in,
    output wire [17:2]               multi_function_io_in,
    // General I/O pins
    input  wire [`PFPM_GIO_W-1:0]    gio_out,
    input  wire [`PFPM_GIO_W-1:0]    gio_oe_n,
    input  wire [`PFPM_GIO_W-1:0]    gio_pin_in,
    output wire [`PFPM_GIO_W-1:0]    gio_pin_out,
    output wire [`PFPM_GIO_W-1:0]    gio_pin_oe_n,
    output wire [`PFPM_GIO_W-1:0]    gio_pin_pull_dn,
    output wire [`PFPM_GIO_W-1:0]    gio_in,
    // Memory pins
    input  wire [`PFPM_MEM_DW-1:0]   mem_data_out,
    input  wire                      mem_data_oe_n,
    input  wire [`PFPM_MEM_AW-1:0]   mem_addr_out,
    input  wire [`PFPM_MEM_CW-1:0]   mem_ctrl_out,
    output reg  [`PFPM_MEM_DW-1:0]   mem_data_pin_out,
    output reg                       mem_data_pin_oe_n,
    output reg  [`PFPM_MEM_AW-1:0]   mem_addr_pin_out,
    output reg  [`PFPM_MEM_CW-1:0]   mem_ctrl_pin_out,
    output reg                       mem_ctrl_pin_oe_n,
    // Read strobe and boot select
    input  wire                      read_strobe_n_out,
    input  wire                      boot_chip_select_n_out,
    output reg                       read_strobe_n_pin,
    output reg                       read_strobe_n_pin_oe_n,
    output reg                       boot_chip_select_n,
    output reg                       boot_chip_select_n_oe_n,
    output reg                       boot_chip_select_n_pull_dn,
    // Codec bus and fast IR
    input  wire                      frame_sync_out,
    input  wire                      data_out_out,
    input  wire                      serial_clock_out,
    input  wire                      fast_ir_out,
    output reg                       codec_bus_frame_sync,
    output reg                       codec_bus_data_out,
    output reg                       codec_bus_serial_clock,
    output reg                       fast_ir_transmit,
    input  wire                      codec_bus_data_in,
    input  wire                      codec_bus_irq_in,
    output reg                       codec_data_in_sync,
    output reg                       codec_irq_in_sync,
    output reg                       codec_in_pull_dn
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [`PFPM_ST_W-1:0]  state_r;
    reg [`PFPM_ST_W-1:0]  state_nxt;
    reg                   armed_r;
    reg                   armed_nxt;
    reg [15:0]            mf_sel_r;
    reg [15:0]            mf_slp_en_r;
    reg [15:0]            mf_slp_drv_r;
    reg [15:0]            mf_slp_lvl_r;
    reg [`PFPM_GIO_W-1:0] gio_slp_en_r;
    reg [`PFPM_GIO_W-1:0] gio_slp_drv_r;
    reg [`PFPM_GIO_W-1:0] gio_slp_lvl_r;
    reg [4:0]             sync1_r;
    reg [4:0]             sync2_r;
    reg                   button_prev_r;
    wire                  por_n_s;
    wire                  button_s;
    wire                  supply_s;
    wire                  button_rise;
    wire                  pd;
    wire                  in_por;
    wire                  live_pd;
    wire                  gsleep_nxt;
    wire                  mem_off;
    wire [15:0]           mf_sleep;
    wire [`PFPM_GIO_W-1:0] gio_sleep;
    wire [15:0]           mf_por_low;
    wire [`PFPM_GIO_W-1:0] cfg_gio;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Two flops on the power-on reset, on-button, supply present and codec inputs
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_r       <= 5'h00;
            sync2_r       <= 5'h00;
            button_prev_r <= 1'b0;
        end else begin
            sync1_r       <= {codec_bus_irq_in, codec_bus_data_in,
                              system_supply_present, on_button,
                              power_on_reset_n};
            sync2_r       <= sync1_r;
            button_prev_r <= sync2_r[1];
        end
    end

    assign por_n_s     = sync2_r[0];
    assign button_s    = sync2_r[1];
    assign supply_s    = sync2_r[2];
    assign button_rise = button_s & ~button_prev_r;

    // ----------------------------------------
    // Power-down terms
    // ----------------------------------------
    // Power-down when either supply indication is low
    assign pd         = ~(main_supply_on & supply_s);
    assign power_down = pd;
    assign in_por     = state_r == `PFPM_ST_POR;
    assign live_pd    = pd & armed_r;
    // Fixed pins follow the next phase, in step with power_state
    assign gsleep_nxt = state_nxt != `PFPM_ST_RUN;
    assign mf_sleep   = {16{live_pd}} & mf_slp_en_r;
    assign gio_sleep  = {`PFPM_GIO_W{live_pd}} & gio_slp_en_r;
    assign mf_por_low = `PFPM_MF_POR_LOW;
    assign mem_off    = memory_sleep_condition |
                        (state_nxt == `PFPM_ST_POR);

    // ----------------------------------------
    // Power state sequencer
    // ----------------------------------------
    // Reset, running and sleep phases
    always @* begin
        state_nxt = state_r;
        armed_nxt = armed_r;
        case (state_r)
            `PFPM_ST_POR: begin
                armed_nxt = 1'b0;
                if (button_rise) begin
                    state_nxt = `PFPM_ST_RUN;
                end
            end
            `PFPM_ST_RUN: begin
                if (!armed_r && supply_s) begin
                    armed_nxt = 1'b1;
                end
                if (armed_r && pd) begin
                    state_nxt = `PFPM_ST_SLEEP;
                end
            end
            `PFPM_ST_SLEEP: begin
                // Block stays clocked while the system is unpowered
                if (button_rise) begin
                    state_nxt = `PFPM_ST_RUN;
                    armed_nxt = 1'b0;
                end else if (!pd) begin
                    state_nxt = `PFPM_ST_RUN;
                end
            end
            default: begin
                state_nxt = `PFPM_ST_POR;
                armed_nxt = 1'b0;
            end
        endcase
        if (!por_n_s) begin
            state_nxt = `PFPM_ST_POR;
            armed_nxt = 1'b0;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= `PFPM_ST_POR;
            armed_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign power_state = state_r;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Software writes after power-up
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mf_sel_r      <= `PFPM_MF_SEL_RST;
            mf_slp_en_r   <= `PFPM_MF_SLP_RST;
            mf_slp_drv_r  <= 16'h0000;
            mf_slp_lvl_r  <= 16'h0000;
            gio_slp_en_r  <= `PFPM_GIO_SLP_RST;
            gio_slp_drv_r <= 12'h000;
            gio_slp_lvl_r <= 12'h000;
        end else if (cfg_wr_en) begin
            case (cfg_wr_addr)
                `PFPM_A_MF_SEL:      mf_sel_r      <= cfg_wr_data;
                `PFPM_A_MF_SLP_EN:   mf_slp_en_r   <= cfg_wr_data;
                `PFPM_A_MF_SLP_DRV:  mf_slp_drv_r  <= cfg_wr_data;
                `PFPM_A_MF_SLP_LVL:  mf_slp_lvl_r  <= cfg_wr_data;
                `PFPM_A_GIO_SLP_EN:  gio_slp_en_r  <= cfg_gio;
                `PFPM_A_GIO_SLP_DRV: gio_slp_drv_r <= cfg_gio;
                `PFPM_A_GIO_SLP_LVL: gio_slp_lvl_r <= cfg_gio;
                default:             mf_sel_r      <= mf_sel_r;
            endcase
        end
    end

    assign cfg_gio                     = cfg_wr_data[`PFPM_GIO_W-1:0];
    assign multi_function_select       = mf_sel_r;
    assign multi_function_sleep_enable = mf_slp_en_r;
    assign general_io_sleep_enable     = gio_slp_en_r;

    // ----------------------------------------
    // Multiplexed and general I/O pins
    // ----------------------------------------
    genvar gi;
    generate
        // Multi-function bits 17..2
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_mf
            pfpm_pin_cell u_cell (
                .clock       (clock),
                .resetn      (resetn),
                .sel         (mf_sel_r[gi]),
                .por         (in_por),
                .por_low     (mf_por_low[gi]),
                .sleep       (mf_sleep[gi]),
                .slp_drive   (mf_slp_drv_r[gi]),
                .slp_level   (mf_slp_lvl_r[gi]),
                .std_out     (mf_std_out[gi+2]),
                .std_oe_n    (mf_std_oe_n[gi+2]),
                .mio_out     (multi_function_io_out[gi+2]),
                .mio_oe_n    (multi_function_io_oe_n[gi+2]),
                .pin_in      (mf_pin_in[gi+2]),
                .pin_out     (mf_pin_out[gi+2]),
                .pin_oe_n    (mf_pin_oe_n[gi+2]),
                .pin_pull_dn (mf_pin_pull_dn[gi+2]),
                .std_in      (mf_std_in[gi+2]),
                .mio_in      (multi_function_io_in[gi+2])
            );
        end
        // Dedicated general I/O, no multi-function path
        for (gi = 0; gi < `PFPM_GIO_W; gi = gi + 1) begin : g_gio
            pfpm_pin_cell u_cell (
                .clock       (clock),
                .resetn      (resetn),
                .sel         (1'b0),
                .por         (in_por),
                .por_low     (1'b0),
                .sleep       (gio_sleep[gi]),
                .slp_drive   (gio_slp_drv_r[gi]),
                .slp_level   (gio_slp_lvl_r[gi]),
                .std_out     (gio_out[gi]),
                .std_oe_n    (gio_oe_n[gi]),
                .mio_out     (1'b0),
                .mio_oe_n    (1'b1),
                .pin_in      (gio_pin_in[gi]),
                .pin_out     (gio_pin_out[gi]),
                .pin_oe_n    (gio_pin_oe_n[gi]),
                .pin_pull_dn (gio_pin_pull_dn[gi]),
                .std_in      (gio_in[gi]),
                .mio_in      ()
            );
        end
    endgenerate

    // ----------------------------------------
    // Memory pins
    // ----------------------------------------
    // Low when memory sleeps; released on bus grant
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mem_data_pin_out  <= 32'h00000000;
            mem_data_pin_oe_n <= 1'b0;
            mem_addr_pin_out  <= 13'h0000;
            mem_ctrl_pin_out  <= 12'h000;
            mem_ctrl_pin_oe_n <= 1'b0;
        end else begin
            if (mem_off) begin
                mem_data_pin_out <= 32'h00000000;
                mem_addr_pin_out <= 13'h0000;
                mem_ctrl_pin_out <= 12'h000;
            end else begin
                mem_data_pin_out <= mem_data_out;
                mem_addr_pin_out <= mem_addr_out;
                mem_ctrl_pin_out <= mem_ctrl_out;
            end
            mem_data_pin_oe_n <= ~bus_grant_n |
                                 (~mem_off & mem_data_oe_n);
            mem_ctrl_pin_oe_n <= ~bus_grant_n;
        end
    end

    // ----------------------------------------
    // Fixed pins and power outputs
    // ----------------------------------------
    // Each follows the phase of the next state, except the 32 kHz enable and the read strobe enable
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            system_power_switch        <= 1'b0;
            sys_osc_enable             <= 1'b0;
            osc_6mhz_enable            <= 1'b0;
            osc_32khz_enable           <= 1'b1;
            read_strobe_n_pin          <= 1'b0;
            read_strobe_n_pin_oe_n     <= 1'b0;
            boot_chip_select_n         <= 1'b0;
            boot_chip_select_n_oe_n    <= 1'b1;
            boot_chip_select_n_pull_dn <= 1'b1;
            codec_bus_frame_sync       <= 1'b0;
            codec_bus_data_out         <= 1'b0;
            codec_bus_serial_clock     <= 1'b0;
            fast_ir_transmit           <= 1'b0;
            codec_data_in_sync         <= 1'b0;
            codec_irq_in_sync          <= 1'b0;
            codec_in_pull_dn           <= 1'b1;
        end else begin
            system_power_switch <= state_nxt == `PFPM_ST_RUN;
            sys_osc_enable      <= ~gsleep_nxt;
            osc_6mhz_enable     <= ~gsleep_nxt;
            osc_32khz_enable    <= 1'b1;
            read_strobe_n_pin   <= ~gsleep_nxt & read_strobe_n_out;
            read_strobe_n_pin_oe_n <= ~bus_grant_n;
            // Boot select floats onto its pull-down when off
            boot_chip_select_n  <= ~gsleep_nxt &
                                   boot_chip_select_n_out;
            boot_chip_select_n_oe_n    <= gsleep_nxt | ~bus_grant_n;
            boot_chip_select_n_pull_dn <= gsleep_nxt;
            codec_bus_frame_sync   <= ~gsleep_nxt & frame_sync_out;
            codec_bus_data_out     <= ~gsleep_nxt & data_out_out;
            codec_bus_serial_clock <= ~gsleep_nxt & serial_clock_out;
            fast_ir_transmit       <= ~gsleep_nxt & fast_ir_out;
            codec_data_in_sync     <= ~gsleep_nxt & sync2_r[3];
            codec_irq_in_sync      <= ~gsleep_nxt & sync2_r[4];
            codec_in_pull_dn       <= gsleep_nxt;
        end
    end

endmodule

// *** bench/pfpm_top_assertions.sv ***
/* Port checker for pfpm_top: power states, config writes, memory pins.
 Assumes one clock domain and binding to every pfpm_top instance. */
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module pfpm_chk (
    input wire        clock,
    input wire        resetn,
    input wire        main_supply_on,
    input wire        memory_sleep_condition,
    input wire        bus_grant_n,
    input wire        cfg_wr_en,
    input wire [2:0]  cfg_wr_addr,
    input wire [15:0] cfg_wr_data,
    input wire [17:2] multi_function_select,
    input wire [2:0]  power_state,
    input wire        power_down,
    input wire        system_power_switch,
    input wire        sys_osc_enable,
    input wire        osc_32khz_enable,
    input wire [31:0] mem_data_pin_out,
    input wire        mem_data_pin_oe_n,
    input wire        mem_ctrl_pin_oe_n,
    input wire        read_strobe_n_pin
);
    // One domain, checks off during reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    chk_pd_supply: assert property (!main_supply_on |-> power_down)
        else $error("power down low with main supply off");
    chk_osc_32k: assert property (osc_32khz_enable)
        else $error("32k oscillator stopped");
    chk_osc_run: assert property (
        sys_osc_enable == (power_state == 3'h2))
        else $error("system oscillator out of step with state");
    chk_switch_run: assert property (
        system_power_switch == (power_state == 3'h2))
        else $error("power switch out of step with state");
    chk_rd_idle: assert property (
        power_state != 3'h2 |-> !read_strobe_n_pin)
        else $error("read strobe high outside running");
    chk_mem_low: assert property (
        memory_sleep_condition |=> mem_data_pin_out == 32'h0)
        else $error("memory data not low in memory sleep");
    chk_grant_hiz: assert property (
        !bus_grant_n |=> mem_data_pin_oe_n && mem_ctrl_pin_oe_n)
        else $error("memory pins driven under bus grant");
    chk_sel_write: assert property (cfg_wr_en && cfg_wr_addr == 3'h0 |=>
        multi_function_select == $past(cfg_wr_data))
        else $error("select register missed a write");
    cover property (power_state == 3'h4);
    cover property (!bus_grant_n);
    cover property (cfg_wr_en && cfg_wr_addr == 3'h7);
endmodule
bind pfpm_top pfpm_chk u_chk (.*);

// *** bench/pfpm_top_tb.sv ***
/* Bench for pfpm_top: drives every input, queues and compares results.
 Assumes pfpm_chk is bound to the design by its own file. */
`timescale 1ns/1ps
module pfpm_top_tb;
// ----------------------------------------
// Signals
// ----------------------------------------
reg clock, resetn, power_on_reset_n, on_button, system_supply_present;
reg main_supply_on, memory_sleep_condition, bus_grant_n, cfg_wr_en;
reg mem_data_oe_n, read_strobe_n_out, boot_chip_select_n_out, fast_ir_out;
reg frame_sync_out, data_out_out, serial_clock_out, codec_bus_data_in;
reg codec_bus_irq_in;
reg [2:0] cfg_wr_addr;
reg [15:0] cfg_wr_data;
reg [17:2] mf_std_out, mf_std_oe_n, multi_function_io_out, mf_pin_in, s;
reg [17:2] multi_function_io_oe_n;
reg [11:0] gio_out, gio_oe_n, gio_pin_in, mem_ctrl_out;
reg [31:0] mem_data_out, r, e, g, eq[$];
reg [12:0] mem_addr_out;
wire [17:2] multi_function_select, multi_function_sleep_enable, mf_pin_out;
wire [17:2] mf_pin_oe_n, mf_pin_pull_dn, mf_std_in, multi_function_io_in;
wire [11:0] general_io_sleep_enable, gio_pin_out, gio_pin_oe_n, gio_in;
wire [11:0] gio_pin_pull_dn, mem_ctrl_pin_out;
wire [31:0] mem_data_pin_out;
wire [12:0] mem_addr_pin_out;
wire [2:0] power_state;
wire power_down, system_power_switch, sys_osc_enable, osc_6mhz_enable;
wire osc_32khz_enable, mem_data_pin_oe_n, mem_ctrl_pin_oe_n, codec_in_pull_dn;
wire read_strobe_n_pin, read_strobe_n_pin_oe_n, boot_chip_select_n;
wire boot_chip_select_n_oe_n, boot_chip_select_n_pull_dn, fast_ir_transmit;
wire codec_bus_frame_sync, codec_bus_data_out, codec_bus_serial_clock;
wire codec_data_in_sync, codec_irq_in_sync;
integer seed, n_errors, checks, i;
string nm, nq[$];
pfpm_top dut (.*);
// Free-running 25 MHz clock
initial begin
    clock = 0;
    forever #20 clock = ~clock;
end
// Queue one expected value
task chk(input string n, input [31:0] v);
    begin
        nq.push_back(n);
        eq.push_back(v);
    end
endtask
// One-cycle config write, launched at a falling edge
task cfg(input [2:0] a, input [15:0] d);
    begin
        @(negedge clock);
        {cfg_wr_en, cfg_wr_addr, cfg_wr_data} = {1'b1, a, d};
        @(negedge clock);
        cfg_wr_en = 0;
    end
endtask
task finish_test;
    begin
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    end
endtask
// Watchdog
initial begin
    #100000;
    n_errors = n_errors + 1;
    finish_test;
end
// Monitor: pops every queued note, oldest first, compares with settled outputs
always @(negedge clock) begin
    #1;
    while (eq.size() > 0) begin
        nm = nq.pop_front();
        e = eq.pop_front();
        case (nm)
            "sel": g = {16'h0, multi_function_select};
            "slp": g = {16'h0, multi_function_sleep_enable};
            "gio": g = {20'h0, general_io_sleep_enable};
            "st": g = {29'h0, power_state};
            "pwr": g = {26'h0, system_power_switch, sys_osc_enable,
                osc_6mhz_enable, osc_32khz_enable, read_strobe_n_pin,
                boot_chip_select_n_pull_dn};
            "mfo": g = {16'h0, mf_pin_out};
            "gpu": g = {20'h0, gio_pin_pull_dn};
            "moe": g = {30'h0, mem_data_pin_oe_n, mem_ctrl_pin_oe_n};
            "cod": g = {27'h0, codec_bus_frame_sync, codec_bus_data_out,
                codec_bus_serial_clock, fast_ir_transmit, codec_in_pull_dn};
            "boe": g = {29'h0, boot_chip_select_n, boot_chip_select_n_oe_n,
                read_strobe_n_pin_oe_n};
            "gpo": g = {20'h0, gio_pin_out};
            default: g = mem_data_pin_out;
        endcase
        checks = checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    end
end
// Main sequence
initial begin
    {seed, n_errors, checks} = {32'd67, 32'd0, 32'd0};
    {resetn, on_button, system_supply_present, main_supply_on} = 4'h0;
    {memory_sleep_condition, cfg_wr_en, mem_data_oe_n} = 3'h0;
    {power_on_reset_n, bus_grant_n, read_strobe_n_out} = 3'h7;
    {cfg_wr_addr, cfg_wr_data, mem_addr_out} = 32'h0;
    {mf_std_oe_n, multi_function_io_oe_n, gio_oe_n} = 44'h0;
    {mf_std_out, multi_function_io_out, mem_data_out} = 64'h0;
    {mf_pin_in, gio_out, frame_sync_out, data_out_out} = 30'h0;
    {serial_clock_out, fast_ir_out, gio_pin_in, mem_ctrl_out} = 26'h0;
    {codec_bus_data_in, codec_bus_irq_in, boot_chip_select_n_out} = 3'h1;
    repeat (10) @(negedge clock);
    resetn = 1;
    @(negedge clock);
    chk("sel", 32'hC3FF);
    chk("slp", 32'h0FFF);
    chk("gio", 32'hFFF);
    chk("gpu", 32'hFFF);
    chk("st", 32'h1);
    chk("cod", 32'h1);
    chk("pwr", 32'h05);
    {system_supply_present, main_supply_on, on_button} = 3'h7;
    for (i = 0; i < 20 && power_state !== 3'h2; i = i + 1) @(negedge clock);
    on_button = 0;
    chk("st", 32'h2);
    chk("pwr", 32'h3E);
    chk("boe", 32'h4);
    for (i = 0; i < 4; i = i + 1) begin
        r = $random(seed);
        s = r[15:0];
        cfg(3'h0, s);
        r = $random(seed);
        {mf_std_out, multi_function_io_out} = r;
        r = $random(seed);
        {mf_pin_in, gio_out, frame_sync_out, data_out_out} = r[29:0];
        r = $random(seed);
        {gio_pin_in, mem_ctrl_out, mem_addr_out[7:0]} = r;
        {serial_clock_out, fast_ir_out, codec_bus_data_in} = r[2:0];
        mem_data_out = $random(seed);
        repeat (2) @(negedge clock);
        chk("sel", s);
        chk("mfo", (s & multi_function_io_out) | (~s & mf_std_out));
        chk("gpo", gio_out);
        chk("md", mem_data_out);
        chk("cod", {frame_sync_out, data_out_out, serial_clock_out,
            fast_ir_out, 1'b0});
    end
    cfg(3'h7, ~s);
    @(negedge clock);
    chk("sel", s);
    bus_grant_n = 0;
    @(negedge clock);
    chk("moe", 32'h3);
    chk("boe", 32'h7);
    {bus_grant_n, memory_sleep_condition} = 2'h3;
    @(negedge clock);
    chk("md", 32'h0);
    memory_sleep_condition = 0;
    cfg(3'h2, 16'hFFFF);
    cfg(3'h3, 16'hA5A5);
    main_supply_on = 0;
    @(negedge clock);
    chk("st", 32'h4);
    chk("pwr", 32'h05);
    @(negedge clock);
    chk("mfo", 16'h05A5 | ((s & multi_function_io_out) |
        (~s & mf_std_out)) & 16'hF000);
    chk("gpu", 32'hFFF);
    chk("cod", 32'h1);
    main_supply_on = 1;
    @(negedge clock);
    chk("st", 32'h2);
    @(negedge clock);
    #2 finish_test;
end
endmodule
